// ==== hdl/synth_cfg_pkg.sv ====
`default_nettype none
package synth_cfg_pkg;
  localparam int N_INST = 8;
  localparam logic [3:0] MAX_NOTES = 4'h8;
  // Node parameter indices, byte address is index times four
  localparam logic [7:0] IX_MERGE = 8'h08;
  localparam logic [7:0] IX_RECV = 8'h0D;
  localparam logic [7:0] IX_NODE = 8'h20;
  localparam logic [7:0] IX_PROT = 8'h21;
  localparam logic [7:0] IX_CFG = 8'h22;
  localparam logic [7:0] IX_TUNE = 8'h23;
  localparam logic [7:0] IX_LEVEL = 8'h24;
  localparam logic [7:0] IX_CHAIN = 8'h25;
  localparam logic [7:0] IX_STAT = 8'h30;
  // Instrument parameter indices
  localparam logic [3:0] IX_ALLOC = 4'h0;
  localparam logic [3:0] IX_CHAN = 4'h1;
  localparam logic [3:0] IX_HI = 4'h2;
  localparam logic [3:0] IX_LO = 4'h3;
  localparam logic [3:0] IX_BANK = 4'h4;
  localparam logic [3:0] IX_VOICE = 4'h5;
  localparam logic [3:0] IX_DETUNE = 4'h6;
  localparam logic [3:0] IX_OCT = 4'h7;
  localparam logic [3:0] IX_ILEVEL = 4'h8;
  localparam logic [3:0] IX_PAN = 4'h9;
  localparam logic [3:0] IX_LFOOFF = 4'hA;
  // Instrument block window: bits 11:9 select it, 8:6 instrument, 5:2 index
  localparam logic [2:0] INST_WIN = 3'h1;
  // Range limits
  localparam logic [1:0] RECV_MAX = 2'h2;
  localparam logic [4:0] CFG_MAX = 5'h13;
  localparam logic [2:0] BANK_MAX = 3'h6;
  localparam logic [5:0] VOICE_MAX = 6'h2F;
  localparam logic [2:0] OCT_MAX = 3'h4;
  localparam logic [2:0] OCT_CENTER = 3'h2;
  localparam logic [6:0] FULL7 = 7'h7F;
  // Reset values
  localparam logic [3:0] RST_ALLOC = 4'h1;
  localparam logic [6:0] RST_HI = 7'h7F;
  localparam logic [6:0] RST_LO = 7'h00;
  localparam logic [6:0] RST_ILEVEL = 7'h7F;
  localparam logic [6:0] RST_PAN = 7'h40;
  localparam logic [6:0] RST_LEVEL = 7'h7F;
  typedef struct packed {
    logic [3:0] alloc;
    logic [3:0] chan;
    logic [6:0] hi;
    logic [6:0] lo;
    logic [2:0] bank;
    logic [5:0] voice;
    logic [6:0] detune;
    logic [2:0] oct;
    logic [6:0] level;
    logic [6:0] pan;
    logic lfo_off;
  } inst_cfg_s;
  typedef struct packed {
    logic [2:0] inst;
    logic [6:0] note;
    logic on;
    logic single_note_performance;
    logic signed [2:0] oct_shift;
    logic [6:0] detune;
    logic [6:0] level;
    logic [6:0] pan_l;
    logic [6:0] pan_r;
    logic lfo_en;
    logic [2:0] bank;
    logic [5:0] voice;
  } route_s;
  typedef enum logic {SC_IDLE, SC_SCAN} scan_e;
endpackage
`default_nettype wire

// ==== hdl/synth_config_parameter_bank.sv ====
// What this block does
// - Voice switch loads voice and function data; merge mode 0 keeps function data.
// - Note filter code 0 accepts all, 1 even only, 2 odd only.
// - Card holds node number 0-15; exclusive messages match it.
// - Write protect 1 blocks voice and config RAM writes; resets to 0.
// - Active configuration index takes values 0 to 19.
// - Global tune is 7-bit two's complement, -64 to +63.
// - Global level 0 to 127 scales the whole card.
// - Overflow forward 1 sends excess note-ons out; 0 disables.
// - Allocation 0-8; total above eight trims the largest other instrument.
// - Allocation of exactly one plays monophonically.
// - Instrument acts only on messages of its own channel 0-15.
// - Shared-channel instruments process a message lowest number first.
// - Upper note limit 0-127, reset 127, bounds the highest note.
// - Lower note limit 0-127, reset 0, bounds the lowest note.
// - Seven banks of 48 voices; bank index 0 to 6.
// - Voice index 0 to 47 within the active bank.
// - Bank change keeps the stored voice index.
// - Fine pitch offset -64 to +63 around zero.
// - Octave code 0..4 decodes to -2..+2 octaves.
// - Instrument level 0 to 127, 127 loudest.
// - Pan 0 left, 64 both, 127 right.
// - Modulation disable 1 suppresses shared LFO; 0 allows it.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module synth_config_parameter_bank (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ev_valid,
  input wire logic [3:0] ev_chan,
  input wire logic [6:0] ev_note,
  input wire logic ev_on,
  output logic ev_ready,
  output logic route_valid,
  output synth_cfg_pkg::route_s route,
  output logic fwd_valid,
  output logic [3:0] fwd_chan,
  output logic [6:0] fwd_note,
  input wire logic exc_valid,
  input wire logic [3:0] exc_node,
  output logic node_hit,
  input wire logic mem_wr_req,
  output logic mem_wr_en,
  output logic mem_wr_block,
  output logic ld_valid,
  output logic [2:0] ld_inst,
  output logic [2:0] ld_bank,
  output logic [5:0] ld_voice,
  output logic ld_func,
  output logic [4:0] cfg_index,
  output logic signed [6:0] master_tune,
  output logic [6:0] master_level,
  output logic [7:0] single_note_performance_map
);
  synth_cfg_pkg::inst_cfg_s cfg_r [synth_cfg_pkg::N_INST];
  logic [3:0] cnt_r [synth_cfg_pkg::N_INST];
  logic merge_r, prot_r, chain_r;
  logic [1:0] recv_r;
  logic [3:0] node_r;
  logic [2:0] last_r;
  logic [31:0] rd_nxt;
  logic err_nxt, inst_sel, wr_go, val_ok;
  logic [7:0] nix;
  logic [3:0] iix;
  logic [2:0] isel;
  logic [6:0] total, wd7;
  logic [2:0] maxi;
  synth_cfg_pkg::scan_e st_r;
  logic [2:0] si_r;
  logic [3:0] ech_r;
  logic [6:0] enote_r;
  logic eon_r, acc_r, hit_r, m_now, take_now;

  function automatic logic [6:0] sum_alloc(input synth_cfg_pkg::inst_cfg_s c [synth_cfg_pkg::N_INST]);
    logic [6:0] s;
    s = '0;
    for (int i = 0; i < synth_cfg_pkg::N_INST; i++)
    begin
      s = s + {3'h0, c[i].alloc};
    end
    return s;
  endfunction

  function automatic logic [2:0] pick_max(input synth_cfg_pkg::inst_cfg_s c [synth_cfg_pkg::N_INST],
                                           input logic [2:0] excl);
    logic [2:0] m;
    logic [3:0] v;
    m = '0;
    v = '0;
    for (int i = 0; i < synth_cfg_pkg::N_INST; i++)
    begin
      if (3'(i) != excl && c[i].alloc > v)
      begin
        m = 3'(i);
        v = c[i].alloc;
      end
    end
    return m;
  endfunction

  assign nix = paddr[9:2];
  assign iix = paddr[5:2];
  assign isel = paddr[8:6];
  assign inst_sel = paddr[11:9] == synth_cfg_pkg::INST_WIN;
  assign wd7 = pwdata[6:0];
  assign total = sum_alloc(cfg_r);
  assign maxi = pick_max(cfg_r, last_r);
  assign wr_go = psel && penable && pready && pwrite && !pslverr;

  // Decode, range check and read mux
  always_comb
  begin
    rd_nxt = '0;
    val_ok = 1'b1;
    err_nxt = 1'b0;
    if (inst_sel)
    begin
      case (iix)
        synth_cfg_pkg::IX_ALLOC:
        begin
          rd_nxt[3:0] = cfg_r[isel].alloc;
          val_ok = pwdata[31:4] == '0 && pwdata[3:0] <= synth_cfg_pkg::MAX_NOTES;
        end
        synth_cfg_pkg::IX_CHAN: rd_nxt[3:0] = cfg_r[isel].chan;
        synth_cfg_pkg::IX_HI: rd_nxt[6:0] = cfg_r[isel].hi;
        synth_cfg_pkg::IX_LO: rd_nxt[6:0] = cfg_r[isel].lo;
        synth_cfg_pkg::IX_BANK:
        begin
          rd_nxt[2:0] = cfg_r[isel].bank;
          val_ok = pwdata[2:0] <= synth_cfg_pkg::BANK_MAX;
        end
        synth_cfg_pkg::IX_VOICE:
        begin
          rd_nxt[5:0] = cfg_r[isel].voice;
          val_ok = pwdata[5:0] <= synth_cfg_pkg::VOICE_MAX;
        end
        synth_cfg_pkg::IX_DETUNE: rd_nxt[6:0] = cfg_r[isel].detune;
        synth_cfg_pkg::IX_OCT:
        begin
          rd_nxt[2:0] = cfg_r[isel].oct;
          val_ok = pwdata[2:0] <= synth_cfg_pkg::OCT_MAX;
        end
        synth_cfg_pkg::IX_ILEVEL: rd_nxt[6:0] = cfg_r[isel].level;
        synth_cfg_pkg::IX_PAN: rd_nxt[6:0] = cfg_r[isel].pan;
        synth_cfg_pkg::IX_LFOOFF: rd_nxt[0] = cfg_r[isel].lfo_off;
        default: err_nxt = 1'b1;
      endcase
    end
    else if (paddr[11:10] != 2'h0)
    begin
      err_nxt = 1'b1;
    end
    else
    begin
      case (nix)
        synth_cfg_pkg::IX_MERGE: rd_nxt[0] = merge_r;
        synth_cfg_pkg::IX_RECV:
        begin
          rd_nxt[1:0] = recv_r;
          val_ok = pwdata[1:0] <= synth_cfg_pkg::RECV_MAX;
        end
        synth_cfg_pkg::IX_NODE: rd_nxt[3:0] = node_r;
        synth_cfg_pkg::IX_PROT: rd_nxt[0] = prot_r;
        synth_cfg_pkg::IX_CFG:
        begin
          rd_nxt[4:0] = cfg_index;
          val_ok = pwdata[4:0] <= synth_cfg_pkg::CFG_MAX;
        end
        synth_cfg_pkg::IX_TUNE: rd_nxt[6:0] = master_tune;
        synth_cfg_pkg::IX_LEVEL: rd_nxt[6:0] = master_level;
        synth_cfg_pkg::IX_CHAIN: rd_nxt[0] = chain_r;
        synth_cfg_pkg::IX_STAT: rd_nxt = {23'h00_0000, total, !ev_ready, st_r == synth_cfg_pkg::SC_SCAN};
        default: err_nxt = 1'b1;
      endcase
    end
    if (pwrite && !val_ok)
    begin
      err_nxt = 1'b1;
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && err_nxt;
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : '0;
    end
  end

  // Node parameters
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      merge_r <= 1'b0;
      recv_r <= '0;
      node_r <= '0;
      prot_r <= 1'b0;
      cfg_index <= '0;
      master_tune <= '0;
      master_level <= synth_cfg_pkg::RST_LEVEL;
      chain_r <= 1'b0;
    end
    else if (wr_go && !inst_sel)
    begin
      case (nix)
        synth_cfg_pkg::IX_MERGE: merge_r <= pwdata[0];
        synth_cfg_pkg::IX_RECV: recv_r <= pwdata[1:0];
        synth_cfg_pkg::IX_NODE: node_r <= pwdata[3:0];
        synth_cfg_pkg::IX_PROT: prot_r <= pwdata[0];
        synth_cfg_pkg::IX_CFG: cfg_index <= pwdata[4:0];
        synth_cfg_pkg::IX_TUNE: master_tune <= wd7;
        synth_cfg_pkg::IX_LEVEL: master_level <= wd7;
        synth_cfg_pkg::IX_CHAIN: chain_r <= pwdata[0];
        default: chain_r <= chain_r;
      endcase
    end
  end

  // Instrument parameters and allocation trimming
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      last_r <= '0;
      for (int i = 0; i < synth_cfg_pkg::N_INST; i++)
      begin
        cfg_r[i] <= '{alloc: synth_cfg_pkg::RST_ALLOC, chan: 4'(i), hi: synth_cfg_pkg::RST_HI,
                      lo: synth_cfg_pkg::RST_LO, bank: '0, voice: '0, detune: '0,
                      oct: synth_cfg_pkg::OCT_CENTER, level: synth_cfg_pkg::RST_ILEVEL,
                      pan: synth_cfg_pkg::RST_PAN, lfo_off: 1'b0};
      end
    end
    else if (wr_go && inst_sel)
    begin
      case (iix)
        synth_cfg_pkg::IX_ALLOC:
        begin
          cfg_r[isel].alloc <= pwdata[3:0];
          last_r <= isel;
        end
        synth_cfg_pkg::IX_CHAN: cfg_r[isel].chan <= pwdata[3:0];
        synth_cfg_pkg::IX_HI: cfg_r[isel].hi <= wd7;
        synth_cfg_pkg::IX_LO: cfg_r[isel].lo <= wd7;
        synth_cfg_pkg::IX_BANK: cfg_r[isel].bank <= pwdata[2:0];
        synth_cfg_pkg::IX_VOICE: cfg_r[isel].voice <= pwdata[5:0];
        synth_cfg_pkg::IX_DETUNE: cfg_r[isel].detune <= wd7;
        synth_cfg_pkg::IX_OCT: cfg_r[isel].oct <= pwdata[2:0];
        synth_cfg_pkg::IX_ILEVEL: cfg_r[isel].level <= wd7;
        synth_cfg_pkg::IX_PAN: cfg_r[isel].pan <= wd7;
        synth_cfg_pkg::IX_LFOOFF: cfg_r[isel].lfo_off <= pwdata[0];
        default: last_r <= last_r;
      endcase
    end
    // Trim largest other by one per cycle
    else if (total > {3'h0, synth_cfg_pkg::MAX_NOTES})
    begin
      cfg_r[maxi].alloc <= cfg_r[maxi].alloc - 4'h1;
    end
  end

  // Voice switch load requests
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ld_valid <= 1'b0;
      ld_inst <= '0;
      ld_bank <= '0;
      ld_voice <= '0;
      ld_func <= 1'b0;
    end
    else
    begin
      ld_valid <= wr_go && inst_sel && (iix == synth_cfg_pkg::IX_BANK || iix == synth_cfg_pkg::IX_VOICE);
      ld_inst <= isel;
      // Same voice index in new bank
      ld_bank <= (iix == synth_cfg_pkg::IX_BANK) ? pwdata[2:0] : cfg_r[isel].bank;
      ld_voice <= (iix == synth_cfg_pkg::IX_VOICE) ? pwdata[5:0] : cfg_r[isel].voice;
      ld_func <= merge_r;
    end
  end

  // Node match, memory guard and single_note_performance map
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      node_hit <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wr_block <= 1'b0;
      single_note_performance_map <= '0;
    end
    else
    begin
      node_hit <= exc_valid && exc_node == node_r;
      mem_wr_en <= mem_wr_req && !prot_r;
      mem_wr_block <= mem_wr_req && prot_r;
      for (int i = 0; i < synth_cfg_pkg::N_INST; i++)
      begin
        single_note_performance_map[i] <= cfg_r[i].alloc == 4'h1;
      end
    end
  end

  // Channel and range match of scanned instrument
  assign m_now = cfg_r[si_r].chan == ech_r && enote_r <= cfg_r[si_r].hi && enote_r >= cfg_r[si_r].lo;
  assign take_now = m_now && (eon_r ? cnt_r[si_r] < cfg_r[si_r].alloc : cnt_r[si_r] != 4'h0);

  // Event scan over instruments
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= synth_cfg_pkg::SC_IDLE;
      si_r <= '0;
      ech_r <= '0;
      enote_r <= '0;
      eon_r <= 1'b0;
      acc_r <= 1'b0;
      hit_r <= 1'b0;
      ev_ready <= 1'b1;
      fwd_valid <= 1'b0;
      fwd_chan <= '0;
      fwd_note <= '0;
      for (int i = 0; i < synth_cfg_pkg::N_INST; i++)
      begin
        cnt_r[i] <= '0;
      end
    end
    else
    begin
      fwd_valid <= 1'b0;
      case (st_r)
        synth_cfg_pkg::SC_IDLE:
        begin
          ev_ready <= 1'b1;
          if (ev_valid && ev_ready && (recv_r == 2'h0 || ev_note[0] == recv_r[1]))
          begin
            st_r <= synth_cfg_pkg::SC_SCAN;
            ev_ready <= 1'b0;
            si_r <= '0;
            ech_r <= ev_chan;
            enote_r <= ev_note;
            eon_r <= ev_on;
            acc_r <= 1'b0;
            hit_r <= 1'b0;
          end
        end
        synth_cfg_pkg::SC_SCAN:
        begin
          if (take_now)
          begin
            cnt_r[si_r] <= eon_r ? cnt_r[si_r] + 4'h1 : cnt_r[si_r] - 4'h1;
          end
          acc_r <= acc_r || take_now;
          hit_r <= hit_r || m_now;
          si_r <= si_r + 3'h1;
          if (si_r == 3'h7)
          begin
            st_r <= synth_cfg_pkg::SC_IDLE;
            ev_ready <= 1'b1;
            fwd_valid <= chain_r && eon_r && !(acc_r || take_now) && (hit_r || m_now);
            fwd_chan <= ech_r;
            fwd_note <= enote_r;
          end
        end
        default: st_r <= synth_cfg_pkg::SC_IDLE;
      endcase
    end
  end

  // Routed note with decoded instrument settings
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      route_valid <= 1'b0;
      route <= '0;
    end
    else
    begin
      route_valid <= st_r == synth_cfg_pkg::SC_SCAN && take_now;
      route.inst <= si_r;
      route.note <= enote_r;
      route.on <= eon_r;
      route.single_note_performance <= cfg_r[si_r].alloc == 4'h1;
      route.oct_shift <= 3'(cfg_r[si_r].oct - synth_cfg_pkg::OCT_CENTER);
      route.detune <= cfg_r[si_r].detune;
      route.level <= cfg_r[si_r].level;
      route.pan_l <= synth_cfg_pkg::FULL7 - cfg_r[si_r].pan;
      route.pan_r <= cfg_r[si_r].pan;
      route.lfo_en <= !cfg_r[si_r].lfo_off;
      route.bank <= cfg_r[si_r].bank;
      route.voice <= cfg_r[si_r].voice;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_protect_block: assert property (mem_wr_req && prot_r |=> !mem_wr_en && mem_wr_block)
    else $error("protected write passed");
  a_node_match: assert property (exc_valid && exc_node == node_r |=> node_hit)
    else $error("node match missed");
  a_cfg_range: assert property (cfg_index <= synth_cfg_pkg::CFG_MAX)
    else $error("config index out of range");
  a_filter_even: assert property (ev_valid && ev_ready && recv_r == 2'h1 && ev_note[0] |=> ev_ready)
    else $error("odd note taken in even mode");
  a_trim_step: assert property (total > 7'h08 && !(wr_go && inst_sel) |=> total == $past(total) - 7'h01)
    else $error("allocation not trimmed");
  a_scan_order: assert property (route_valid ##1 route_valid |-> route.inst > $past(route.inst))
    else $error("instruments out of order");
  a_route_limits: assert property (route_valid |-> route.note <= cfg_r[route.inst].hi
                                   && route.note >= cfg_r[route.inst].lo)
    else $error("note outside limits");
  a_fwd_chain: assert property (fwd_valid |-> chain_r && $past(st_r) == synth_cfg_pkg::SC_SCAN)
    else $error("forward without chain");
  a_merge_load: assert property (wr_go && inst_sel && iix == synth_cfg_pkg::IX_BANK
                                 |=> ld_valid && ld_func == merge_r && ld_voice == $past(cfg_r[isel].voice))
    else $error("voice load wrong");
endmodule
`default_nettype wire

// ==== verification/apb_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input wire logic sys_clk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  output logic exc_valid,
  output logic [3:0] exc_node
);
  initial
  begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    exc_valid = 1'b0;
    exc_node = 4'h0;
  end
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
    begin
      @(posedge sys_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
      begin
        @(posedge sys_clk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
    end
  endtask
  task send_exc(input logic [3:0] nd);
    @(posedge sys_clk);
    exc_valid <= 1'b1;
    exc_node <= nd;
    @(posedge sys_clk);
    exc_valid <= 1'b0;
    exc_node <= ~nd;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, rd;
  logic ev_valid = 1'b0;
  logic ev_on = 1'b0;
  logic [3:0] ev_chan = 4'h0;
  logic [6:0] ev_note = 7'h00;
  logic mem_wr_req = 1'b0;
  logic ev_ready, route_valid, fwd_valid, exc_valid, node_hit, mem_wr_en, mem_wr_block, ld_valid, ld_func, err;
  logic [3:0] fwd_chan, exc_node;
  logic [6:0] fwd_note, fwd_seen, master_level;
  synth_cfg_pkg::route_s route;
  synth_cfg_pkg::route_s rq[$];
  logic [2:0] ld_inst, ld_bank;
  logic [5:0] ld_voice;
  logic [12:0] ld_seen;
  logic [4:0] cfg_index;
  logic signed [6:0] master_tune;
  logic [7:0] single_note_performance_map;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int fwd_cnt, ld_cnt, hit_cnt, blk_cnt, en_cnt;
  typedef struct {logic [11:0] a; logic [31:0] wd; logic e; logic [31:0] rb;} row_s;
  row_s rows[17] = '{
    '{12'h034, 32'h0000_0003, 1'b1, 32'h0000_0000}, '{12'h034, 32'h0000_0001, 1'b0, 32'h0000_0001},
    '{12'h088, 32'h0000_0013, 1'b0, 32'h0000_0013}, '{12'h088, 32'h0000_0014, 1'b1, 32'h0000_0013},
    '{12'h08C, 32'h0000_0040, 1'b0, 32'h0000_0040}, '{12'h090, 32'h0000_0000, 1'b0, 32'h0000_0000},
    '{12'h250, 32'h0000_0006, 1'b0, 32'h0000_0006}, '{12'h250, 32'h0000_0007, 1'b1, 32'h0000_0006},
    '{12'h254, 32'h0000_002F, 1'b0, 32'h0000_002F}, '{12'h254, 32'h0000_0030, 1'b1, 32'h0000_002F},
    '{12'h21C, 32'h0000_0000, 1'b0, 32'h0000_0000}, '{12'h21C, 32'h0000_0005, 1'b1, 32'h0000_0000},
    '{12'h228, 32'h0000_0001, 1'b0, 32'h0000_0001}, '{12'h0FC, 32'h0000_0001, 1'b1, 32'h0000_0000},
    '{12'h240, 32'h0000_0009, 1'b1, 32'h0000_0001}, '{12'h080, 32'h0000_0005, 1'b0, 32'h0000_0005},
    '{12'h218, 32'h0000_0040, 1'b0, 32'h0000_0040}};

  always #20 sys_clk = ~sys_clk;

  apb_host_model i_host (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .exc_valid(exc_valid), .exc_node(exc_node));

  synth_config_parameter_bank i_dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev_valid(ev_valid), .ev_chan(ev_chan), .ev_note(ev_note), .ev_on(ev_on),
    .ev_ready(ev_ready), .route_valid(route_valid), .route(route), .fwd_valid(fwd_valid),
    .fwd_chan(fwd_chan), .fwd_note(fwd_note), .exc_valid(exc_valid), .exc_node(exc_node),
    .node_hit(node_hit), .mem_wr_req(mem_wr_req), .mem_wr_en(mem_wr_en), .mem_wr_block(mem_wr_block),
    .ld_valid(ld_valid), .ld_inst(ld_inst), .ld_bank(ld_bank), .ld_voice(ld_voice), .ld_func(ld_func),
    .cfg_index(cfg_index), .master_tune(master_tune), .master_level(master_level), .single_note_performance_map(single_note_performance_map));

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(a, 1'b1, d, rd, err);
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(a, 1'b0, 32'h0000_0000, rd, err);
    chk(nm, rd, exp);
  endtask
  task note(input logic [3:0] c, input logic [6:0] n, input logic on);
    rq.delete();
    fwd_cnt = 0;
    @(posedge sys_clk);
    ev_valid <= 1'b1;
    ev_chan <= c;
    ev_note <= n;
    ev_on <= on;
    @(posedge sys_clk);
    ev_valid <= 1'b0;
    ev_note <= ~n;
    repeat (12) @(posedge sys_clk);
  endtask
  task pulse_mem;
    blk_cnt = 0;
    en_cnt = 0;
    @(posedge sys_clk);
    mem_wr_req <= 1'b1;
    @(posedge sys_clk);
    mem_wr_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // Output capture and hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (route_valid === 1'b1) rq.push_back(route);
    if (fwd_valid === 1'b1)
    begin
      fwd_cnt++;
      fwd_seen = fwd_note;
    end
    if (ld_valid === 1'b1)
    begin
      ld_cnt++;
      ld_seen = {ld_inst, ld_func, ld_bank, ld_voice};
    end
    if (node_hit === 1'b1) hit_cnt++;
    if (mem_wr_block === 1'b1) blk_cnt++;
    if (mem_wr_en === 1'b1) en_cnt++;
    if (cyc == 5000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("master_level", 32'(master_level), 32'h0000_007F);
    chk("single_note_performance_map", 32'(single_note_performance_map), 32'h0000_00FF);
    chk("ev_ready", 32'(ev_ready), 32'h0000_0001);
    rdc("protect", 12'h084, 32'h0000_0000);
    rdc("hi", 12'h208, 32'h0000_007F);
    rdc("lo", 12'h20C, 32'h0000_0000);
    rdc("pan", 12'h224, 32'h0000_0040);
    rdc("ilevel", 12'h220, 32'h0000_007F);
    rdc("chan3", 12'h2C4, 32'h0000_0003);
    rdc("status", 12'h0C0, 32'h0000_0020);
    $display("reset test done");
    foreach (rows[i])
    begin
      i_host.xfer(rows[i].a, 1'b1, rows[i].wd, rd, err);
      chk("slverr", {31'h0, err}, {31'h0, rows[i].e});
      rdc("readback", rows[i].a, rows[i].rb);
    end
    chk("master_tune", {25'h0, master_tune}, 32'h0000_0040);
    chk("cfg_index", 32'(cfg_index), 32'h0000_0013);
    chk("level_out", 32'(master_level), 32'h0000_0000);
    $display("table test done");
    wr(12'h084, 32'h0000_0001);
    pulse_mem();
    chk("blocked", blk_cnt + en_cnt * 2, 32'h0000_0001);
    wr(12'h084, 32'h0000_0000);
    pulse_mem();
    chk("granted", blk_cnt + en_cnt * 2, 32'h0000_0002);
    hit_cnt = 0;
    i_host.send_exc(4'h5);
    i_host.send_exc(4'h4);
    repeat (3) @(posedge sys_clk);
    chk("node_hit", hit_cnt, 32'h0000_0001);
    $display("protect and node test done");
    note(4'h0, 7'd61, 1'b1);
    chk("odd_routes", rq.size(), 32'h0000_0000);
    wr(12'h284, 32'h0000_0000);
    wr(12'h244, 32'h0000_0000);
    note(4'h0, 7'd60, 1'b1);
    chk("routes", rq.size(), 32'h0000_0003);
    chk("first_inst", 32'(rq[0].inst), 32'h0000_0000);
    chk("second_inst", 32'(rq[1].inst), 32'h0000_0001);
    chk("third_inst", 32'(rq[2].inst), 32'h0000_0002);
    chk("single_note_performance", 32'(rq[0].single_note_performance), 32'h0000_0001);
    chk("oct_shift", {29'h0, rq[0].oct_shift}, 32'h0000_0006);
    chk("oct_center", {29'h0, rq[1].oct_shift}, 32'h0000_0000);
    chk("lfo_en", 32'({rq[0].lfo_en, rq[1].lfo_en}), 32'h0000_0001);
    chk("pan", 32'({rq[0].pan_l, rq[0].pan_r}), {18'h0, 7'h3F, 7'h40});
    chk("tone", 32'({rq[0].note, rq[0].level, rq[0].detune}), {11'h0, 7'd60, 7'h7F, 7'h40});
    chk("voice_sel", 32'({rq[1].bank, rq[1].voice}), {23'h0, 3'h6, 6'h2F});
    wr(12'h094, 32'h0000_0001);
    note(4'h0, 7'd62, 1'b1);
    chk("full_routes", rq.size(), 32'h0000_0000);
    chk("fwd", {17'h0, fwd_cnt[3:0], fwd_chan, fwd_seen}, {17'h0, 4'h1, 4'h0, 7'd62});
    wr(12'h288, 32'h0000_0032);
    note(4'h0, 7'd60, 1'b0);
    chk("off_routes", rq.size(), 32'h0000_0002);
    chk("off_inst", 32'({rq[0].inst, rq[0].on}), 32'h0000_0000);
    wr(12'h034, 32'h0000_0002);
    note(4'h0, 7'd60, 1'b1);
    chk("even_drop", rq.size(), 32'h0000_0000);
    note(4'h0, 7'd61, 1'b1);
    chk("odd_take", rq.size(), 32'h0000_0002);
    $display("note test done");
    ld_cnt = 0;
    wr(12'h250, 32'h0000_0003);
    repeat (3) @(posedge sys_clk);
    chk("ld_cnt", ld_cnt, 32'h0000_0001);
    chk("ld_bank", 32'(ld_seen), {19'h0, 3'h1, 1'b0, 3'h3, 6'h2F});
    wr(12'h020, 32'h0000_0001);
    wr(12'h254, 32'h0000_0005);
    repeat (3) @(posedge sys_clk);
    chk("ld_merge", 32'(ld_seen), {19'h0, 3'h1, 1'b1, 3'h3, 6'h05});
    $display("voice load test done");
    wr(12'h200, 32'h0000_0008);
    repeat (12) @(posedge sys_clk);
    chk("single_note_performance_map8", 32'(single_note_performance_map), 32'h0000_0000);
    rdc("total", 12'h0C0, 32'h0000_0020);
    rdc("alloc0", 12'h200, 32'h0000_0008);
    rdc("alloc1", 12'h240, 32'h0000_0000);
    $display("allocation test done");
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("rst_single_note_performance", 32'(single_note_performance_map), 32'h0000_00FF);
    chk("rst_cfg", 32'(cfg_index), 32'h0000_0000);
    chk("rst_level", 32'(master_level), 32'h0000_007F);
    rdc("rst_alloc0", 12'h200, 32'h0000_0001);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
